// ===== hdl/sbma_pkg.sv
// Package: constants and types for the system bus master arbiter
package sbma_pkg;

  localparam int unsigned NUM_MASTERS      = 3;
  localparam logic [1:0]  MASTER_CORE      = 2'h0;
  localparam logic [1:0]  MASTER_INTERNAL  = 2'h1;
  localparam logic [1:0]  MASTER_DMA       = 2'h2;

  localparam logic [3:0]  CTRL_ADDR        = 4'h0;
  localparam logic [3:0]  STATUS_ADDR      = 4'h1;

  localparam int unsigned BOOST_EN_BIT     = 25;
  localparam int unsigned WIDE_SEL_BIT     = 24;
  localparam int unsigned DMA_PRIO_LSB     = 20;
  localparam int unsigned CORE_PRIO_LSB    = 18;
  localparam int unsigned INT_PRIO_LSB     = 16;
  localparam int unsigned FIXED_MODE_BIT   = 14;
  localparam int unsigned TIMEOUT_EN_BIT   = 13;
  localparam int unsigned PARK_SEL_BIT     = 12;
  localparam int unsigned LOCK_EXP_LSB     = 8;
  localparam logic [31:0] CTRL_WRITE_MASK  = 32'h033F_7F00;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

  localparam logic [1:0]  DEFAULT_PRIO_DMA  = 2'h2;
  localparam logic [1:0]  DEFAULT_PRIO_INT  = 2'h1;
  localparam logic [1:0]  DEFAULT_PRIO_CORE = 2'h0;
  localparam logic [1:0]  GRANT_RESET       = 2'h0;
  localparam int unsigned LOCK_CNT_W        = 16;
  localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_RESET = 16'h0000;

  typedef struct packed {
    logic       boost_enable;
    logic       wide_select;
    logic [1:0] dma_prio;
    logic [1:0] core_prio;
    logic [1:0] int_prio;
    logic       fixed_mode;
    logic       timeout_enable;
    logic       park_highest;
    logic [3:0] lock_exp;
  } sbma_ctrl_type;

  typedef enum logic [1:0] {
    SBMA_IDLE    = 2'b00,
    SBMA_BUSY    = 2'b01,
    SBMA_ESCAL   = 2'b11
  } sbma_state_type;

endpackage

// ===== hdl/sbma_arbiter.sv
// System bus master arbiter with control register port
//
// Functional notes
// - Three masters: DMA, internal, core
// - Bit 25 lets DMA boost priority
// - Bit 24 selects DMA counter width
// - Bits 21-20 hold DMA priority
// - Bits 19-18 hold core priority
// - Bits 17-16 hold internal master priority
// - Bit 14 picks fixed or round-robin
// - Bit 13 enables lock-out counting
// - Bit 12 picks idle park target
// - Lock-out limit is two to field
// - Default order: higher index ranks higher
// - Duplicate priorities fall back to default
// - Round-robin default; finisher drops to lowest
// - Fixed mode: winner holds until done
// - Timeout escalates to round-robin until clear
// - Round-robin ignores timeout settings
`timescale 1ns/1ps

module sbma_arbiter (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [31:0] reg_rdata_out,
  input  wire logic [2:0]  bus_request_in,
  input  wire logic [2:0]  transfer_done_in,
  input  wire logic        dma_boost_request_in,
  output logic      [2:0]  bus_grant_out,
  output logic      [1:0]  park_master_out,
  output logic             dma_count_wide_out
);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [31:0] arbitration_control_q;
  sbma_pkg::sbma_ctrl_type ctrl;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arbitration_control_q <= sbma_pkg::CTRL_RESET;
    end else if (reg_write_in && reg_addr_in == sbma_pkg::CTRL_ADDR) begin
      arbitration_control_q <= reg_wdata_in & sbma_pkg::CTRL_WRITE_MASK;
    end
  end

  always_comb begin
    ctrl.boost_enable   = arbitration_control_q[sbma_pkg::BOOST_EN_BIT];
    ctrl.wide_select    = arbitration_control_q[sbma_pkg::WIDE_SEL_BIT];
    ctrl.dma_prio       = arbitration_control_q[sbma_pkg::DMA_PRIO_LSB +: 2];
    ctrl.core_prio      = arbitration_control_q[sbma_pkg::CORE_PRIO_LSB +: 2];
    ctrl.int_prio       = arbitration_control_q[sbma_pkg::INT_PRIO_LSB +: 2];
    ctrl.fixed_mode     = arbitration_control_q[sbma_pkg::FIXED_MODE_BIT];
    ctrl.timeout_enable = arbitration_control_q[sbma_pkg::TIMEOUT_EN_BIT];
    ctrl.park_highest   = arbitration_control_q[sbma_pkg::PARK_SEL_BIT];
    ctrl.lock_exp       = arbitration_control_q[sbma_pkg::LOCK_EXP_LSB +: 4];
  end

  // ----------------------------------------------------------------
  // Effective priorities
  // ----------------------------------------------------------------
  logic [1:0] prio [3];
  logic       prio_unique;

  always_comb begin
    prio_unique = (ctrl.dma_prio != ctrl.core_prio) && (ctrl.dma_prio != ctrl.int_prio)
                  && (ctrl.core_prio != ctrl.int_prio);
    if (prio_unique) begin
      prio[sbma_pkg::MASTER_DMA]      = ctrl.dma_prio;
      prio[sbma_pkg::MASTER_INTERNAL] = ctrl.int_prio;
      prio[sbma_pkg::MASTER_CORE]     = ctrl.core_prio;
    end else begin
      prio[sbma_pkg::MASTER_DMA]      = sbma_pkg::DEFAULT_PRIO_DMA;
      prio[sbma_pkg::MASTER_INTERNAL] = sbma_pkg::DEFAULT_PRIO_INT;
      prio[sbma_pkg::MASTER_CORE]     = sbma_pkg::DEFAULT_PRIO_CORE;
    end
  end

  // Highest requester by score; ties go to higher index
  function automatic logic [1:0] pick_best(input logic [2:0] req,
                                           input logic [2:0] s0,
                                           input logic [2:0] s1,
                                           input logic [2:0] s2);
    logic [1:0] best;
    logic [2:0] bs;
    logic       any;
    best = 2'h0;
    bs   = 3'h0;
    any  = 1'b0;
    if (req[2]) begin
      best = 2'h2;
      bs   = s2;
      any  = 1'b1;
    end
    if (req[1] && (!any || s1 > bs)) begin
      best = 2'h1;
      bs   = s1;
      any  = 1'b1;
    end
    if (req[0] && (!any || s0 > bs)) begin
      best = 2'h0;
    end
    return best;
  endfunction

  // ----------------------------------------------------------------
  // Shared state and helpers
  // ----------------------------------------------------------------
  localparam int unsigned LOCK_W = sbma_pkg::LOCK_CNT_W;

  logic [1:0]               rr_rank_q [3];
  logic [1:0]               rr_rank_d [3];
  logic [LOCK_W-1:0]        lock_cnt_q [3];
  logic [LOCK_W-1:0]        lock_cnt_d [3];
  logic [LOCK_W:0]          lock_limit;
  logic [2:0]               lock_hit;
  logic                     use_rr;
  logic [2:0]               boost;
  sbma_pkg::sbma_state_type state_q;
  sbma_pkg::sbma_state_type state_d;
  logic                     granted_q;
  logic                     granted_d;
  logic                     take_new;
  logic [1:0]               grant_idx_q;
  logic [1:0]               last_q;
  logic [1:0]               winner;
  logic                     done_now;
  logic                     any_request;
  logic                     escalate;
  logic [1:0]               highest;
  logic [31:0]              status_word;

  // Master index compare for counters, ranks and grant
  function automatic logic idx_match(input logic [1:0] idx, input int m);
    return idx == 2'(m);
  endfunction

  // ----------------------------------------------------------------
  // Lock-out counters
  // ----------------------------------------------------------------
  assign lock_limit = (LOCK_W+1)'(1) << ctrl.lock_exp;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lock_hit[i] = ctrl.timeout_enable && ({1'b0, lock_cnt_q[i]} >= lock_limit);
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!ctrl.fixed_mode || !ctrl.timeout_enable || !bus_request_in[i]
          || (granted_q && idx_match(grant_idx_q, i))) begin
        lock_cnt_d[i] = sbma_pkg::LOCK_CNT_RESET;
      end else if (lock_cnt_q[i] != {LOCK_W{1'b1}}) begin
        lock_cnt_d[i] = lock_cnt_q[i] + 1'b1;
      end else begin
        lock_cnt_d[i] = lock_cnt_q[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 3; i++) begin
        lock_cnt_q[i] <= sbma_pkg::LOCK_CNT_RESET;
      end
    end else begin
      lock_cnt_q <= lock_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Round-robin rank
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!done_now) begin
        rr_rank_d[i] = rr_rank_q[i];
      end else if (idx_match(grant_idx_q, i)) begin
        rr_rank_d[i] = 2'h0;
      end else if (rr_rank_q[i] < rr_rank_q[grant_idx_q]) begin
        rr_rank_d[i] = rr_rank_q[i] + 2'h1;
      end else begin
        rr_rank_d[i] = rr_rank_q[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rr_rank_q[0] <= sbma_pkg::DEFAULT_PRIO_CORE;
      rr_rank_q[1] <= sbma_pkg::DEFAULT_PRIO_INT;
      rr_rank_q[2] <= sbma_pkg::DEFAULT_PRIO_DMA;
    end else begin
      rr_rank_q <= rr_rank_d;
    end
  end

  // ----------------------------------------------------------------
  // Winner selection
  // ----------------------------------------------------------------
  // Timeout only matters in fixed mode
  assign use_rr      = !ctrl.fixed_mode || (state_q == sbma_pkg::SBMA_ESCAL);
  assign boost       = {ctrl.boost_enable && dma_boost_request_in, 2'b00};
  assign any_request = |bus_request_in;
  assign done_now    = granted_q && transfer_done_in[grant_idx_q];

  always_comb begin
    if (use_rr) begin
      winner = pick_best(bus_request_in, {boost[0], rr_rank_q[0]},
                         {boost[1], rr_rank_q[1]}, {boost[2], rr_rank_q[2]});
    end else begin
      winner = pick_best(bus_request_in, {boost[0], prio[0]},
                         {boost[1], prio[1]}, {boost[2], prio[2]});
    end
  end

  // ----------------------------------------------------------------
  // Escalation state
  // ----------------------------------------------------------------
  assign escalate = (|lock_hit) && ctrl.fixed_mode;

  always_comb begin
    case (state_q)
      sbma_pkg::SBMA_IDLE: begin
        if (escalate) begin
          state_d = sbma_pkg::SBMA_ESCAL;
        end else if (any_request) begin
          state_d = sbma_pkg::SBMA_BUSY;
        end else begin
          state_d = sbma_pkg::SBMA_IDLE;
        end
      end
      sbma_pkg::SBMA_BUSY: begin
        if (escalate) begin
          state_d = sbma_pkg::SBMA_ESCAL;
        end else if (!any_request) begin
          state_d = sbma_pkg::SBMA_IDLE;
        end else begin
          state_d = sbma_pkg::SBMA_BUSY;
        end
      end
      sbma_pkg::SBMA_ESCAL: begin
        if (!escalate) begin
          state_d = sbma_pkg::SBMA_BUSY;
        end else begin
          state_d = sbma_pkg::SBMA_ESCAL;
        end
      end
      default: state_d = sbma_pkg::SBMA_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= sbma_pkg::SBMA_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Grant tenure and parking
  // ----------------------------------------------------------------
  assign highest   = pick_best(3'b111, {1'b0, prio[0]}, {1'b0, prio[1]}, {1'b0, prio[2]});
  assign granted_d = (granted_q && !done_now) || any_request;
  assign take_new  = any_request && !(granted_q && !done_now);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      granted_q <= 1'b0;
    end else begin
      granted_q <= granted_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      grant_idx_q <= sbma_pkg::GRANT_RESET;
    end else if (take_new) begin
      grant_idx_q <= winner;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_q <= sbma_pkg::GRANT_RESET;
    end else if (take_new) begin
      last_q <= winner;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_grant_out <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        bus_grant_out[i] <= granted_q && idx_match(grant_idx_q, i);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      park_master_out <= sbma_pkg::GRANT_RESET;
    end else begin
      park_master_out <= ctrl.park_highest ? highest : last_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dma_count_wide_out <= 1'b0;
    end else begin
      dma_count_wide_out <= ctrl.wide_select;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  assign status_word = {24'h00_0000, state_q, granted_q, grant_idx_q, lock_hit};

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (!reg_read_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      case (reg_addr_in)
        sbma_pkg::CTRL_ADDR:   reg_rdata_out <= arbitration_control_q;
        sbma_pkg::STATUS_ADDR: reg_rdata_out <= status_word;
        default:               reg_rdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // Internal master priority limit is left to software

endmodule

// ===== tb/sbma_props.sv
// Checker: arbiter port properties
`timescale 1ns/1ps
module sbma_props (
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [2:0]  bus_request_in,
  input wire logic [2:0]  transfer_done_in,
  input wire logic        dma_boost_request_in,
  input wire logic [2:0]  bus_grant_out,
  input wire logic [1:0]  park_master_out,
  input wire logic        dma_count_wide_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_grant_one_hot: assert property ($onehot0(bus_grant_out))
    else $error("grant not one-hot");
  a_wide_write_cause: assert property ($changed(dma_count_wide_out) |->
    $past(reg_write_in) || $past(reg_write_in, 2)) else $error("wide select moved");
  a_rdata_reserved_zero: assert property ($past(reg_read_in) &&
    $past(reg_addr_in) == sbma_pkg::CTRL_ADDR |->
    (reg_rdata_out & ~sbma_pkg::CTRL_WRITE_MASK) == 32'h0) else $error("reserved bit set");
  a_grant_has_cause: assert property (bus_grant_out != 3'h0 && $past(bus_grant_out) == 3'h0
    |-> ($past(bus_request_in, 2) & bus_grant_out) != 3'h0) else $error("grant without request");
  a_dma_grant_delay: assert property ($rose(bus_request_in[2]) &&
    bus_request_in[1:0] == 2'h0 && bus_grant_out == 3'h0 |-> ##2 bus_grant_out == 3'h4)
    else $error("dma grant late");
  a_grant_tenure_hold: assert property (bus_grant_out != 3'h0 && transfer_done_in == 3'h0 &&
    $past(transfer_done_in) == 3'h0 && $past(transfer_done_in, 2) == 3'h0 |=> $stable(bus_grant_out))
    else $error("grant moved in tenure");
  a_grant_release: assert property ((transfer_done_in & bus_grant_out) != 3'h0 &&
    bus_request_in == 3'h0 |-> ##2 bus_grant_out == 3'h0) else $error("grant not released");
  a_park_in_range: assert property (park_master_out != 2'h3)
    else $error("park index out of range");
  c_dma_grant: cover property (bus_grant_out == 3'h4);
  c_done_seen: cover property (transfer_done_in != 3'h0);
  c_boost_win: cover property (dma_boost_request_in && bus_grant_out == 3'h4);
endmodule
bind sbma_arbiter sbma_props u_props (.sys_clk_in, .rst_n_in, .reg_addr_in, .reg_write_in,
  .reg_read_in, .reg_rdata_out, .bus_request_in, .transfer_done_in, .dma_boost_request_in,
  .bus_grant_out, .park_master_out, .dma_count_wide_out);

// ===== tb/sbma_master_model.sv
// Model of the three bus masters
`timescale 1ns/1ps
module sbma_master_model (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [2:0] start_in,
  input  wire logic [3:0] hold_in,
  input  wire logic [2:0] bus_grant_in,
  output logic      [2:0] bus_request_out,
  output logic      [2:0] transfer_done_out
);
  logic [3:0] cnt_q [3];
  // Request held until own transfer ends
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_request_out   <= 3'h0;
      transfer_done_out <= 3'h0;
      cnt_q             <= '{4'h0, 4'h0, 4'h0};
    end else begin
      for (int i = 0; i < 3; i++) begin
        transfer_done_out[i] <= 1'b0;
        if (bus_request_out[i] && bus_grant_in[i]) begin
          cnt_q[i] <= cnt_q[i] + 4'h1;
          if (cnt_q[i] == hold_in) begin
            transfer_done_out[i] <= 1'b1;
            bus_request_out[i]   <= 1'b0;
            cnt_q[i]             <= 4'h0;
          end
        end else if (start_in[i]) begin
          bus_request_out[i] <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== tb/tb.sv
// Testbench: register and arbitration sequences
`timescale 1ns/1ps
module tb;
  logic        sys_clk_in, rst_n_in, reg_write_in, reg_read_in, dma_boost_request_in;
  logic [3:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [2:0]  bus_request_in, transfer_done_in, bus_grant_out, start;
  logic [1:0]  park_master_out;
  logic        dma_count_wide_out;
  int          miscompares, n_tests, cycles;
  localparam logic [3:0] CA = sbma_pkg::CTRL_ADDR;
  sbma_arbiter dut (.sys_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
    .reg_read_in, .reg_rdata_out, .bus_request_in, .transfer_done_in, .dma_boost_request_in,
    .bus_grant_out, .park_master_out, .dma_count_wide_out);
  sbma_master_model u_masters (.sys_clk_in, .rst_n_in, .start_in(start), .hold_in(4'h3),
    .bus_grant_in(bus_grant_out), .bus_request_out(bus_request_in),
    .transfer_done_out(transfer_done_in));
  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    if (miscompares == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string name);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge sys_clk_in);
    reg_read_in <= 1'b0;
    @(negedge sys_clk_in);
    chk(reg_rdata_out, exp, "rdata");
  endtask
  // Start masters, expect grants in order
  task automatic run(input logic [2:0] m, input logic [2:0] g0, g1, g2);
    logic [2:0] exp [3];
    logic [2:0] last;
    exp  = '{g0, g1, g2};
    last = 3'h0;
    @(posedge sys_clk_in);
    start <= m;
    @(posedge sys_clk_in);
    start <= 3'h0;
    for (int k = 0; k < 3; k++) begin
      if (exp[k] != 3'h0) begin
        do @(negedge sys_clk_in); while (bus_grant_out === 3'h0 || bus_grant_out === last);
        chk({29'h0, bus_grant_out}, {29'h0, exp[k]}, "grant");
        last = bus_grant_out;
      end
    end
    do @(negedge sys_clk_in); while (bus_grant_out !== 3'h0 || bus_request_in !== 3'h0);
  endtask
  initial begin
    rst_n_in = 1'b0;
    {reg_write_in, reg_read_in, dma_boost_request_in} = 3'h0;
    reg_addr_in  = 4'h0;
    reg_wdata_in = 32'h0;
    start        = 3'h0;
    repeat (2) @(posedge sys_clk_in);
    chk({26'h0, bus_grant_out, park_master_out, dma_count_wide_out}, 32'h0, "reset outs");
    rst_n_in <= 1'b1;
    rd(CA, sbma_pkg::CTRL_RESET);
    rd(sbma_pkg::STATUS_ADDR, 32'h0);
    rd(4'hF, 32'h0);
    wr(CA, 32'h0339_7F00);
    rd(CA, 32'h0339_7F00);
    chk({31'h0, dma_count_wide_out}, 32'h1, "wide");
    wr(CA, 32'h0);
    rd(CA, 32'h0);
    chk({31'h0, dma_count_wide_out}, 32'h0, "wide");
    run(3'h4, 3'h4, 3'h0, 3'h0);
    run(3'h5, 3'h1, 3'h4, 3'h0);
    wr(CA, 32'h000D_4000);
    dma_boost_request_in <= 1'b1;
    run(3'h7, 3'h1, 3'h2, 3'h4);
    repeat (4) @(negedge sys_clk_in);
    chk({30'h0, park_master_out}, 32'h2, "park last");
    wr(CA, 32'h020D_4000);
    run(3'h7, 3'h4, 3'h1, 3'h2);
    wr(CA, 32'h0015_4000);
    dma_boost_request_in <= 1'b0;
    run(3'h7, 3'h4, 3'h2, 3'h1);
    wr(CA, 32'h000D_5000);
    repeat (4) @(negedge sys_clk_in);
    chk({30'h0, park_master_out}, 32'h0, "park high");
    wr(CA, 32'h000D_6200);
    run(3'h7, 3'h1, 3'h4, 3'h2);
    wr(CA, 32'h000D_6F00);
    run(3'h7, 3'h1, 3'h2, 3'h4);
    final_report();
  end
endmodule
